/* common/hdsp_defines.vh */
// register offsets, field positions and reset values of the host doorbell and swap block
`ifndef HDSP_DEFINES_VH
`define HDSP_DEFINES_VH

`define HDSP_ADDR_W            24
`define HDSP_ALIAS_BIT         4
`define HDSP_OFF_UTIL_DB       24'hFFF021
`define HDSP_OFF_WR_SWAP       24'hFFF023
`define HDSP_OFF_RD_SWAP       24'hFFF025
`define HDSP_OFF_HOST_IRQ      24'hFFF027
`define HDSP_OFF_RX_DB         24'hFFF029
`define HDSP_OFF_TX_DB         24'hFFF02B
`define HDSP_OFF_XTRA_DB       24'hFFF02D
`define HDSP_OFF_PAGE_SEL      24'hFFF041
`define HDSP_OFF_WIN_JUMPER    24'hFFF0C1
`define HDSP_BIT_POS           7
`define HDSP_BIT_RESET         1'h0
`define HDSP_PAGE_RESET        8'h00
`define HDSP_PAGE_LO           12
`define HDSP_PAGE_HI           19
`define HDSP_LVL_UTIL          3'h1
`define HDSP_LVL_XTRA          3'h2
`define HDSP_LVL_TX            3'h3
`define HDSP_LVL_RX            3'h4
`define HDSP_LVL_NONE          3'h0

`endif

/* src/hdsp_byte_swap.v */
// host word data path with byte-swap option latched per bus cycle
`timescale 1ns/1ps

module hdsp_byte_swap (
	input  wire        clk,
	input  wire        reset,
	input  wire        cycle_active,
	input  wire        swap_ctrl,
	input  wire [15:0] data_in,
	output reg  [15:0] data_out
);

	reg swap_latched_reg;

	// the control is sampled only between cycles so a change never splits a word
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			swap_latched_reg <= 1'h0;
			data_out         <= 16'h0000;
		end else begin
			if (!cycle_active) begin
				swap_latched_reg <= swap_ctrl;
			end
			if (cycle_active ? swap_latched_reg : swap_ctrl) begin
				data_out <= {data_in[7:0], data_in[15:8]};
			end else begin
				data_out <= data_in;
			end
		end
	end

endmodule

/* src/hdsp_regs.v */
// host doorbell, byte swap, page and window jumper registers
// ****************************************************************
// Functional notes
// ****************************************************************
// Functional notes
// - window register reads jumpers in bits 7..1, bit 0 reads zero.
// - single-bit registers use bit 7, other bits undefined, cleared by reset.
// - local processor and host master may both set or clear each bit.
// - host interrupt bit drives the jumper-selected host interrupt line.
// - host interrupt register decodes at base and base plus 0x10.
// - receive doorbell holds level 4 request while set.
// - receive doorbell decodes at base and base plus 0x10.
// - utility doorbell holds level 1 request while set.
// - utility doorbell and all single-bit registers decode at base and alias.
// - write swap bit set swaps bytes of host word writes.
// - swap change reaches the data path only after current cycle.
// - read swap bit set swaps bytes of host word reads.
// - transmit doorbell holds level 3 request while set.
// - extra doorbell holds level 2 request while set.
// - page register is eight bits, write only.
// - paged host access drives local address 19..12 from page register.
// - system bus initialize resets all registers.
// - local requests pass only while the interrupt gate is set.
`timescale 1ns/1ps
`include "hdsp_defines.vh"

module hdsp_regs (
	input  wire        clk,
	input  wire        reset,
	input  wire        bus_init,
	input  wire        cpu_sel,
	input  wire        cpu_wr,
	input  wire [23:0] cpu_addr,
	input  wire [7:0]  cpu_wdata,
	input  wire        host_sel,
	input  wire        host_wr,
	input  wire [23:0] host_addr,
	input  wire [7:0]  host_wdata,
	input  wire [6:0]  window_address_jumpers,
	input  wire [2:0]  host_irq_level_jumper,
	input  wire        local_irq_gate,
	input  wire        host_paged_access,
	input  wire [11:0] host_page_offset,
	input  wire        host_cycle_active,
	input  wire [15:0] host_wr_data,
	input  wire [15:0] dram_rd_data,
	output reg  [7:0]  cpu_rdata,
	output reg  [7:0]  host_rdata,
	output reg  [7:0]  host_irq_lines,
	output reg  [2:0]  local_irq_level,
	output reg  [19:0] local_page_addr,
	output wire [15:0] ram_wr_data,
	output wire [15:0] host_rd_data
);

	// ****************************************************************
	// decode
	// ****************************************************************
	localparam IDX_UTIL = 3'h0;
	localparam IDX_WRSW = 3'h1;
	localparam IDX_RDSW = 3'h2;
	localparam IDX_HIRQ = 3'h3;
	localparam IDX_RX   = 3'h4;
	localparam IDX_TX   = 3'h5;
	localparam IDX_XTRA = 3'h6;
	localparam IDX_NONE = 3'h7;

	// alias bit is ignored so each single-bit register answers at two addresses
	function [2:0] bit_index;
		input [23:0] a;
		reg   [23:0] m;
		begin
			m = a & ~(24'h000001 << `HDSP_ALIAS_BIT);
			case (m)
				`HDSP_OFF_UTIL_DB:  bit_index = IDX_UTIL;
				`HDSP_OFF_WR_SWAP:  bit_index = IDX_WRSW;
				`HDSP_OFF_RD_SWAP:  bit_index = IDX_RDSW;
				`HDSP_OFF_HOST_IRQ: bit_index = IDX_HIRQ;
				`HDSP_OFF_RX_DB:    bit_index = IDX_RX;
				`HDSP_OFF_TX_DB:    bit_index = IDX_TX;
				`HDSP_OFF_XTRA_DB:  bit_index = IDX_XTRA;
				default:            bit_index = IDX_NONE;
			endcase
		end
	endfunction

	function [7:0] read_mux;
		input [23:0] a;
		input [6:0]  bits;
		input [6:0]  jumpers;
		reg   [2:0]  i;
		begin
			i = bit_index(a);
			read_mux = 8'h00;
			if (i != IDX_NONE) begin
				read_mux = {bits[i], 7'h00};
			end else if (a == `HDSP_OFF_WIN_JUMPER) begin
				read_mux = {jumpers, 1'h0};
			end
		end
	endfunction

	// ****************************************************************
	// single-bit registers and page register
	// ****************************************************************
	reg        util_reg;
	reg        wrsw_reg;
	reg        rdsw_reg;
	reg        hirq_reg;
	reg        rx_reg;
	reg        tx_reg;
	reg        xtra_reg;
	reg  [7:0] page_reg;
	wire [6:0] bits_reg;
	wire [6:0] bits_next;
	wire [2:0] cpu_idx     = bit_index(cpu_addr);
	wire [2:0] host_idx    = bit_index(host_addr);
	wire       any_rst     = reset | bus_init;
	wire       cpu_bit_we  = cpu_sel && cpu_wr && cpu_idx != IDX_NONE;
	wire       host_bit_we = host_sel && host_wr && host_idx != IDX_NONE;
	wire       cpu_bit     = cpu_wdata[`HDSP_BIT_POS];
	wire       host_bit    = host_wdata[`HDSP_BIT_POS];

	// host write applied last: a simultaneous write from both sides lets the host win
	function bit_update;
		input cur;
		input cpu_we;
		input cpu_d;
		input host_we;
		input host_d;
		begin
			bit_update = cur;
			if (cpu_we) begin
				bit_update = cpu_d;
			end
			if (host_we) begin
				bit_update = host_d;
			end
		end
	endfunction

	// ****************************************************************
	// utility doorbell
	// ****************************************************************
	wire util_cpu_we  = cpu_bit_we && cpu_idx == IDX_UTIL;
	wire util_host_we = host_bit_we && host_idx == IDX_UTIL;
	wire util_next    = bit_update(util_reg, util_cpu_we, cpu_bit,
		util_host_we, host_bit);

	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			util_reg <= `HDSP_BIT_RESET;
		end else begin
			util_reg <= util_next;
		end
	end

	// ****************************************************************
	// slave write swap
	// ****************************************************************
	wire wrsw_cpu_we  = cpu_bit_we && cpu_idx == IDX_WRSW;
	wire wrsw_host_we = host_bit_we && host_idx == IDX_WRSW;
	wire wrsw_next    = bit_update(wrsw_reg, wrsw_cpu_we, cpu_bit,
		wrsw_host_we, host_bit);

	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			wrsw_reg <= `HDSP_BIT_RESET;
		end else begin
			wrsw_reg <= wrsw_next;
		end
	end

	// ****************************************************************
	// slave read swap
	// ****************************************************************
	wire rdsw_cpu_we  = cpu_bit_we && cpu_idx == IDX_RDSW;
	wire rdsw_host_we = host_bit_we && host_idx == IDX_RDSW;
	wire rdsw_next    = bit_update(rdsw_reg, rdsw_cpu_we, cpu_bit,
		rdsw_host_we, host_bit);

	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			rdsw_reg <= `HDSP_BIT_RESET;
		end else begin
			rdsw_reg <= rdsw_next;
		end
	end

	// ****************************************************************
	// host interrupt request
	// ****************************************************************
	wire hirq_cpu_we  = cpu_bit_we && cpu_idx == IDX_HIRQ;
	wire hirq_host_we = host_bit_we && host_idx == IDX_HIRQ;
	wire hirq_next    = bit_update(hirq_reg, hirq_cpu_we, cpu_bit,
		hirq_host_we, host_bit);

	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			hirq_reg <= `HDSP_BIT_RESET;
		end else begin
			hirq_reg <= hirq_next;
		end
	end

	// ****************************************************************
	// receive doorbell
	// ****************************************************************
	wire rx_cpu_we  = cpu_bit_we && cpu_idx == IDX_RX;
	wire rx_host_we = host_bit_we && host_idx == IDX_RX;
	wire rx_next    = bit_update(rx_reg, rx_cpu_we, cpu_bit,
		rx_host_we, host_bit);

	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			rx_reg <= `HDSP_BIT_RESET;
		end else begin
			rx_reg <= rx_next;
		end
	end

	// ****************************************************************
	// transmit doorbell
	// ****************************************************************
	wire tx_cpu_we  = cpu_bit_we && cpu_idx == IDX_TX;
	wire tx_host_we = host_bit_we && host_idx == IDX_TX;
	wire tx_next    = bit_update(tx_reg, tx_cpu_we, cpu_bit,
		tx_host_we, host_bit);

	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			tx_reg <= `HDSP_BIT_RESET;
		end else begin
			tx_reg <= tx_next;
		end
	end

	// ****************************************************************
	// extra doorbell
	// ****************************************************************
	wire xtra_cpu_we  = cpu_bit_we && cpu_idx == IDX_XTRA;
	wire xtra_host_we = host_bit_we && host_idx == IDX_XTRA;
	wire xtra_next    = bit_update(xtra_reg, xtra_cpu_we, cpu_bit,
		xtra_host_we, host_bit);

	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			xtra_reg <= `HDSP_BIT_RESET;
		end else begin
			xtra_reg <= xtra_next;
		end
	end

	// bit order follows the decode index
	assign bits_reg  = {xtra_reg, tx_reg, rx_reg, hirq_reg, rdsw_reg, wrsw_reg, util_reg};
	assign bits_next = {xtra_next, tx_next, rx_next, hirq_next, rdsw_next, wrsw_next,
		util_next};

	// ****************************************************************
	// page register
	// ****************************************************************
	// a clash between both sides goes to the local processor
	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			page_reg <= `HDSP_PAGE_RESET;
		end else if (cpu_sel && cpu_wr && cpu_addr == `HDSP_OFF_PAGE_SEL) begin
			page_reg <= cpu_wdata;
		end else if (host_sel && host_wr && host_addr == `HDSP_OFF_PAGE_SEL) begin
			page_reg <= host_wdata;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	reg [2:0] level_next;

	// priority chain presents the highest pending level
	always @* begin
		level_next = `HDSP_LVL_NONE;
		if (local_irq_gate) begin
			if (bits_next[IDX_RX]) begin
				level_next = `HDSP_LVL_RX;
			end else if (bits_next[IDX_TX]) begin
				level_next = `HDSP_LVL_TX;
			end else if (bits_next[IDX_XTRA]) begin
				level_next = `HDSP_LVL_XTRA;
			end else if (bits_next[IDX_UTIL]) begin
				level_next = `HDSP_LVL_UTIL;
			end
		end
	end

	// read data for both sides
	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			cpu_rdata  <= 8'h00;
			host_rdata <= 8'h00;
		end else begin
			cpu_rdata  <= read_mux(cpu_addr, bits_reg, window_address_jumpers);
			host_rdata <= read_mux(host_addr, bits_reg, window_address_jumpers);
		end
	end

	// interrupt outputs follow the write in the same edge
	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			host_irq_lines  <= 8'h00;
			local_irq_level <= `HDSP_LVL_NONE;
		end else begin
			// one line per level; the jumper picks which one the host sees
			host_irq_lines  <= {7'h00, bits_next[IDX_HIRQ]} << host_irq_level_jumper;
			local_irq_level <= level_next;
		end
	end

	// paged window address
	always @(posedge clk or posedge any_rst) begin
		if (any_rst) begin
			local_page_addr <= 20'h00000;
		end else begin
			if (host_paged_access) begin
				local_page_addr <= {page_reg, host_page_offset};
			end else begin
				local_page_addr <= {host_addr[`HDSP_PAGE_HI:`HDSP_PAGE_LO], host_page_offset};
			end
		end
	end

	// ****************************************************************
	// data path
	// ****************************************************************
	hdsp_byte_swap u_wr_swap (
		.clk          (clk),
		.reset        (any_rst),
		.cycle_active (host_cycle_active),
		.swap_ctrl    (bits_reg[IDX_WRSW]),
		.data_in      (host_wr_data),
		.data_out     (ram_wr_data)
	);

	hdsp_byte_swap u_rd_swap (
		.clk          (clk),
		.reset        (any_rst),
		.cycle_active (host_cycle_active),
		.swap_ctrl    (bits_reg[IDX_RDSW]),
		.data_in      (dram_rd_data),
		.data_out     (host_rd_data)
	);

endmodule

/* sim/hdsp_chk_sva.sv */
// assertion checker bound to the host doorbell and swap register block
`timescale 1ns/1ps
module hdsp_chk (
	input wire        clk,
	input wire        reset,
	input wire        bus_init,
	input wire        cpu_sel,
	input wire        cpu_wr,
	input wire [23:0] cpu_addr,
	input wire [7:0]  cpu_wdata,
	input wire        host_sel,
	input wire [2:0]  host_irq_level_jumper,
	input wire [6:0]  window_address_jumpers,
	input wire        local_irq_gate,
	input wire [7:0]  cpu_rdata,
	input wire [7:0]  host_irq_lines,
	input wire [2:0]  local_irq_level
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset || bus_init);
	// local writes count only while the host is not selected, since the host wins a clash
	wire       rd  = cpu_sel && !cpu_wr;
	wire       wr  = cpu_sel && cpu_wr && !host_sel;
	wire [7:0] hot = 8'h01 << host_irq_level_jumper;
	a_win_read: assert property (rd && cpu_addr == 24'hFFF0C1
		|=> cpu_rdata == {$past(window_address_jumpers), 1'h0}) else $error("bad window read");
	a_page_hidden: assert property (rd && cpu_addr == 24'hFFF041
		|=> cpu_rdata == 8'h00) else $error("page readable");
	a_bit_only: assert property (rd && cpu_addr[23:5] == 19'h7FF81
		|=> cpu_rdata[6:0] == 7'h00) else $error("spare bits set");
	a_rx_alias: assert property (wr && cpu_addr == 24'hFFF039 && cpu_wdata[7] && local_irq_gate
		|=> local_irq_level == 3'h4) else $error("rx level missing");
	a_hirq_alias: assert property (wr && cpu_addr == 24'hFFF037 && cpu_wdata[7]
		|=> host_irq_lines == hot) else $error("host irq not raised");
	a_hirq_clear: assert property (wr && cpu_addr == 24'hFFF027 && !cpu_wdata[7]
		|=> host_irq_lines == 8'h00) else $error("host irq not cleared");
	a_gate_block: assert property (!local_irq_gate && !$past(local_irq_gate)
		|-> local_irq_level == 3'h0) else $error("level past closed gate");
	a_reset_zero: assert property (disable iff (1'h0) reset || bus_init
		|=> local_irq_level == 3'h0 && host_irq_lines == 8'h00) else $error("not reset");
endmodule
bind hdsp_regs hdsp_chk u_chk (.*);

/* sim/hdsp_host_model.sv */
// host-side master model for the host doorbell and swap register block
`timescale 1ns/1ps
module hdsp_host_model (
	input  wire        clk,
	output reg         host_sel   = 1'h0,
	output reg         host_wr    = 1'h0,
	output reg  [23:0] host_addr  = 24'h000000,
	output reg  [7:0]  host_wdata = 8'h00
);
	// released lines show the inverse so a stale value cannot pass for a live one
	task wr(input [23:0] a, input [7:0] d);
		begin
			@(posedge clk) #1;
			{host_sel, host_wr, host_addr, host_wdata} = {2'h3, a, d};
			@(posedge clk) #1;
			{host_sel, host_wr, host_addr, host_wdata} = {2'h0, ~a, ~d};
		end
	endtask
	task rd(input [23:0] a);
		begin
			@(posedge clk) #1;
			{host_sel, host_wr, host_addr} = {2'h2, a};
			@(posedge clk) #1;
			{host_sel, host_addr} = {1'h0, ~a};
		end
	endtask
endmodule

/* sim/hdsp_regs_bench.sv */
// self-checking bench for the host doorbell and swap register block
`timescale 1ns/1ps
module hdsp_regs_bench;
	reg         clk = 1'h0, reset = 1'h1, bus_init = 1'h0, cpu_sel = 1'h0, cpu_wr = 1'h0;
	reg         local_irq_gate = 1'h0, host_paged_access = 1'h0, host_cycle_active = 1'h0;
	reg  [23:0] cpu_addr = 24'h000000, b;
	reg  [7:0]  cpu_wdata = 8'h00;
	reg  [6:0]  window_address_jumpers = 7'h5A;
	reg  [2:0]  host_irq_level_jumper = 3'h5, k;
	reg  [11:0] host_page_offset = 12'h123;
	reg  [15:0] host_wr_data = 16'h1234, dram_rd_data = 16'hABCD;
	reg  [95:0] lt = {24'hFFF039, 24'hFFF02B, 24'hFFF02D, 24'hFFF021};
	wire        host_sel, host_wr;
	wire [23:0] host_addr;
	wire [7:0]  host_wdata, cpu_rdata, host_rdata, host_irq_lines;
	wire [2:0]  local_irq_level;
	wire [19:0] local_page_addr;
	wire [15:0] ram_wr_data, host_rd_data;
	integer     fails = 0, num_checks = 0;
	hdsp_regs DUT (.*);
	hdsp_host_model H (.*);
	always #25 clk = ~clk;
	task wrap_up;
		begin
			if (fails == 0 && num_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task chk(input [39:0] nm, input [19:0] e, input [19:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("BAD %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task tick;
		@(posedge clk) #1;
	endtask
	task cw(input [23:0] a, input [7:0] d);
		begin
			tick;
			{cpu_sel, cpu_wr, cpu_addr, cpu_wdata} = {2'h3, a, d};
			tick;
			{cpu_sel, cpu_wr} = 2'h0;
		end
	endtask
	task cr(input [23:0] a, input [7:0] e);
		begin
			tick;
			{cpu_sel, cpu_addr} = {1'h1, a};
			tick;
			cpu_sel = 1'h0;
			chk("rdata", e, cpu_rdata);
		end
	endtask
	// ****************
	// scenarios
	// ****************
	initial begin
		tick;
		tick;
		reset = 1'h0;
		cr(24'hFFF0C1, 8'hB4);
		for (b = 24'hFFF021; b < 24'hFFF02F; b = b + 24'h2) begin
			cr(b, 8'h00);
			H.wr(b + 24'h10, 8'h80);
			cr(b, 8'h80);
			H.rd(b);
			chk("hrd", 20'h80, host_rdata);
			cw(b, 8'h00);
			cr(b + 24'h10, 8'h00);
		end
		cw(24'hFFF037, 8'h80);
		chk("hirq", 20'h20, host_irq_lines);
		H.wr(24'hFFF027, 8'h00);
		chk("hirq", 20'h00, host_irq_lines);
		local_irq_gate = 1'h1;
		for (k = 3'h0; k < 3'h4; k = k + 3'h1) begin
			cw(lt[24*k +: 24], 8'h80);
			chk("lvl", k + 3'h1, local_irq_level);
		end
		cw(24'hFFF029, 8'h00);
		chk("lvl", 20'h3, local_irq_level);
		local_irq_gate = 1'h0;
		tick;
		tick;
		chk("lvl", 20'h0, local_irq_level);
		{bus_init, local_irq_gate} = 2'h3;
		tick;
		bus_init = 1'h0;
		tick;
		chk("lvl", 20'h0, local_irq_level);
		cr(24'hFFF02B, 8'h00);
		cw(24'hFFF041, 8'hA5);
		cr(24'hFFF041, 8'h00);
		host_paged_access = 1'h1;
		tick;
		tick;
		chk("page", 20'hA5123, local_page_addr);
		cw(24'hFFF033, 8'h80);
		H.wr(24'hFFF025, 8'h80);
		tick;
		tick;
		chk("wswap", 20'h3412, ram_wr_data);
		chk("rswap", 20'hCDAB, host_rd_data);
		host_cycle_active = 1'h1;
		cw(24'hFFF023, 8'h00);
		tick;
		chk("wswap", 20'h3412, ram_wr_data);
		host_cycle_active = 1'h0;
		tick;
		tick;
		chk("wswap", 20'h1234, ram_wr_data);
		wrap_up;
	end
endmodule
